// *** hdl/tcc_pkg.sv ***
// Shared constants, types and register indices of the timer capture/compare block
package tcc_pkg;
  localparam int NCH = 4;
  localparam int CNT_W = 16;
  localparam int BYTE_W = 8;
  localparam int IDX_W = 8;
  localparam int MODE_W = 2;
  localparam int RATE_W = 3;
  localparam int DIV_W = 8;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_MODE = 8'hC1;
  localparam logic [IDX_W-1:0] IDX_RATE = 8'hC9;
  localparam logic [IDX_W-1:0] IDX_CNT_LO = 8'hCC;
  localparam logic [IDX_W-1:0] IDX_CNT_HI = 8'hCD;
  localparam logic [IDX_W-1:0] IDX_SRC = 8'hE0;
  localparam logic [IDX_W-1:0] IDX_FLAG = 8'hE1;
  localparam logic [IDX_W-1:0] IDX_MASK = 8'hE2;
  localparam logic [NCH-1:0][IDX_W-1:0] IDX_VAL_LO = {8'hC6, 8'hC4, 8'hC2, 8'hCA};
  localparam logic [NCH-1:0][IDX_W-1:0] IDX_VAL_HI = {8'hC7, 8'hC5, 8'hC3, 8'hCB};

  // Reset values
  localparam logic [BYTE_W-1:0] MODE_RST = 8'h00;
  localparam logic [RATE_W-1:0] RATE_RST = 3'h0;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [NCH-1:0] FLAG_RST = 4'h0;

  // Divider figures
  localparam logic [DIV_W-1:0] DIV_CPU12 = 8'h0C;
  localparam logic [DIV_W-1:0] DIV_CPU24 = 8'h18;
  localparam logic [DIV_W-1:0] DIV_OSC_MAX = 8'h80;
  localparam logic [RATE_W-1:0] RATE_DIV1 = 3'h7;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [MODE_W-1:0] {MODE_OFF, MODE_CAP_PIN, MODE_COMPARE, MODE_CAP_SW} tcc_mode_t;
  typedef enum logic [1:0] {SRC_OFF, SRC_CPU12, SRC_CPU24, SRC_OSC} tcc_src_t;

  typedef struct packed {
    logic en;
    logic [IDX_W-1:0] idx;
    logic [BYTE_W-1:0] data;
  } tcc_wr_t;
endpackage

// *** hdl/tcc_tick_gen.sv ***
// Count-enable generator: clock source select and oscillator prescaler
`timescale 1ns/100ps
module tcc_tick_gen import tcc_pkg::*; #(
  parameter int W = DIV_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Configuration
  input tcc_src_t srcSel,
  input wire logic [RATE_W-1:0] rateSel,
  // Count enable
  output logic tick
);
  logic [W-1:0] divCnt_reg;
  logic [W-1:0] divisor;
  logic active;

  function automatic logic [W-1:0] divOf(tcc_src_t s, logic [RATE_W-1:0] r);
    unique case (s)
      SRC_CPU12: divOf = W'(DIV_CPU12);
      SRC_CPU24: divOf = W'(DIV_CPU24);
      SRC_OSC: divOf = W'(DIV_OSC_MAX >> r); // see [R1]
      SRC_OFF: divOf = W'(DIV_OSC_MAX);
    endcase
  endfunction

  assign active = srcSel != SRC_OFF; // see [R8]
  assign divisor = divOf(srcSel, rateSel); // see [R8]
  // Compare with >= so a shorter divisor after a rate change never stalls
  assign tick = active && (divCnt_reg >= divisor - W'(1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_reg <= '0;
    end else if (clkEn) begin
      divCnt_reg <= (!active || tick) ? '0 : divCnt_reg + W'(1);
    end
  end
endmodule

// *** hdl/tcc_edge_detect.sv ***
// Capture pin synchroniser and rising edge detector
`timescale 1ns/100ps
module tcc_edge_detect import tcc_pkg::*; #(
  parameter int N = NCH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Pins and edges
  input wire logic [N-1:0] pinIn,
  output logic [N-1:0] rise
);
  logic [N-1:0] syncA_reg;
  logic [N-1:0] syncB_reg;
  logic [N-1:0] prev_reg;

  assign rise = syncB_reg & ~prev_reg; // see [R12]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_reg <= '0;
      syncB_reg <= '0;
      prev_reg <= '0;
    end else if (clkEn) begin
      syncA_reg <= pinIn;
      syncB_reg <= syncA_reg; // see [R12]
      prev_reg <= syncB_reg;
    end
  end
endmodule

// *** hdl/tcc_top.sv ***
// Timer capture/compare block with AXI4-Lite register slave
//
// Overview of operation
// [R1] A 3-bit prescaler field divides the oscillator clock by 128 down to 1 for codes 000 to 111, reset 000.
// [R2] One mode register holds a 2-bit mode per channel, channel 3 highest, all reset to disabled.
// [R3] Mode 01 copies the counter into the channel value on each rising edge of its capture pin.
// [R4] Mode 10 uses the channel value for comparison against the running counter.
// [R5] Mode 11 captures the counter into the channel value when software writes its low byte.
// [R6] The 16-bit up counter is readable and writable as high and low bytes, both reset to zero.
// [R7] Channel 0 value is readable and writable as high and low bytes, both reset to zero.
// [R8] Source select 11 counts the prescaled oscillator, 00 stops, 01 and 10 count the clock over 12 and 24.
// [R9] A software capture stores the counter in place of the written byte.
// [R10] A comparing channel output is low while counter is below the value, high at or above it.
// [R11] A comparing channel sets its match flag when its value equals the counter.
// [R12] Capture pins are synchronised and rising edges found from consecutive synchronised samples.
`timescale 1ns/100ps
module tcc_top import tcc_pkg::*; #(
  parameter int AW = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // AXI4-Lite write address and data
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Channel pins
  input wire logic [NCH-1:0] capturePin,
  output logic [NCH-1:0] compareOut,
  // Interrupt
  output logic irq
);
  // Bus state
  logic awRdy_reg;
  logic wRdy_reg;
  logic bValid_reg;
  logic [1:0] bResp_reg;
  logic arRdy_reg;
  logic rValid_reg;
  logic [1:0] rResp_reg;
  logic [31:0] rData_reg;
  logic [IDX_W-1:0] awIdx_reg;
  logic [BYTE_W-1:0] wData_reg;
  logic wStrb0_reg;

  // Block state
  logic [BYTE_W-1:0] mode_reg;
  logic [RATE_W-1:0] rate_reg;
  tcc_src_t src_reg;
  logic [CNT_W-1:0] counter_reg;
  logic [NCH-1:0][CNT_W-1:0] val_reg;
  logic [NCH-1:0] cmpOut_reg;
  logic [NCH-1:0] flag_reg;
  logic [NCH-1:0] mask_reg;
  logic irq_reg;

  // Decode
  logic doWrite;
  tcc_wr_t wr;
  logic [IDX_W-1:0] arIdx;
  logic wrMode;
  logic wrRate;
  logic wrSrc;
  logic wrFlag;
  logic wrMask;
  logic wrCntLo;
  logic wrCntHi;
  logic cntWr;
  logic tick;
  logic [NCH-1:0] capRise;
  tcc_mode_t chMode [NCH];
  logic [NCH-1:0] wrLo;
  logic [NCH-1:0] wrHi;
  logic [NCH-1:0] capNow;
  logic [NCH-1:0] isCmp;
  logic [NCH-1:0] match;
  logic [NCH-1:0] flagClr;
  logic [BYTE_W-1:0] rdByte;

  function automatic logic isMapped(logic [IDX_W-1:0] idx);
    isMapped = idx == IDX_MODE || idx == IDX_RATE || idx == IDX_CNT_LO || idx == IDX_CNT_HI ||
               idx == IDX_SRC || idx == IDX_FLAG || idx == IDX_MASK;
    for (int c = 0; c < NCH; c++) begin
      isMapped = isMapped || idx == IDX_VAL_LO[c] || idx == IDX_VAL_HI[c];
    end
  endfunction

  tcc_tick_gen #(.W(DIV_W)) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .srcSel(src_reg),
    .rateSel(rate_reg),
    .tick(tick)
  );

  tcc_edge_detect #(.N(NCH)) u_edge (
    .clk(clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .pinIn(capturePin),
    .rise(capRise)
  );

  // Both address and data held, no response outstanding
  assign doWrite = !awRdy_reg && !wRdy_reg && !bValid_reg;
  assign wr.en = doWrite && wStrb0_reg;
  assign wr.idx = awIdx_reg;
  assign wr.data = wData_reg;
  assign arIdx = IDX_W'(s_axi_araddr[AW-1:2]);

  assign wrMode = wr.en && wr.idx == IDX_MODE;
  assign wrRate = wr.en && wr.idx == IDX_RATE;
  assign wrSrc = wr.en && wr.idx == IDX_SRC;
  assign wrFlag = wr.en && wr.idx == IDX_FLAG;
  assign wrMask = wr.en && wr.idx == IDX_MASK;
  assign wrCntLo = wr.en && wr.idx == IDX_CNT_LO;
  assign wrCntHi = wr.en && wr.idx == IDX_CNT_HI;
  assign cntWr = wrCntLo || wrCntHi;
  assign flagClr = wrFlag ? wr.data[NCH-1:0] : '0;

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    assign chMode[c] = tcc_mode_t'(mode_reg[MODE_W*c +: MODE_W]); // see [R2]
    assign wrLo[c] = wr.en && wr.idx == IDX_VAL_LO[c];
    assign wrHi[c] = wr.en && wr.idx == IDX_VAL_HI[c];
    assign capNow[c] = (chMode[c] == MODE_CAP_PIN && capRise[c]) || // see [R3]
                       (chMode[c] == MODE_CAP_SW && wrLo[c]); // see [R5]
    assign isCmp[c] = chMode[c] == MODE_COMPARE; // see [R4]
    assign match[c] = isCmp[c] && counter_reg == val_reg[c]; // see [R11]
  end

  assign s_axi_awready = awRdy_reg;
  assign s_axi_wready = wRdy_reg;
  assign s_axi_bvalid = bValid_reg;
  assign s_axi_bresp = bResp_reg;
  assign s_axi_arready = arRdy_reg;
  assign s_axi_rvalid = rValid_reg;
  assign s_axi_rresp = rResp_reg;
  assign s_axi_rdata = rData_reg;
  assign compareOut = cmpOut_reg;
  assign irq = irq_reg;

  // Write channel: address and data taken in either order
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awRdy_reg <= 1'b1;
      wRdy_reg <= 1'b1;
      bValid_reg <= 1'b0;
      bResp_reg <= RESP_OKAY;
      awIdx_reg <= '0;
      wData_reg <= '0;
      wStrb0_reg <= 1'b0;
    end else if (clkEn) begin
      if (s_axi_awvalid && awRdy_reg) begin
        awIdx_reg <= IDX_W'(s_axi_awaddr[AW-1:2]);
        awRdy_reg <= 1'b0;
      end
      if (s_axi_wvalid && wRdy_reg) begin
        wData_reg <= s_axi_wdata[BYTE_W-1:0];
        wStrb0_reg <= s_axi_wstrb[0];
        wRdy_reg <= 1'b0;
      end
      if (doWrite) begin
        bValid_reg <= 1'b1;
        bResp_reg <= isMapped(awIdx_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (bValid_reg && s_axi_bready) begin
        bValid_reg <= 1'b0;
        awRdy_reg <= 1'b1;
        wRdy_reg <= 1'b1;
      end
    end
  end

  // Read data selection
  always_comb begin
    rdByte = '0;
    if (arIdx == IDX_MODE) rdByte = mode_reg;
    if (arIdx == IDX_RATE) rdByte = BYTE_W'(rate_reg);
    if (arIdx == IDX_SRC) rdByte = BYTE_W'(src_reg);
    if (arIdx == IDX_FLAG) rdByte = BYTE_W'(flag_reg);
    if (arIdx == IDX_MASK) rdByte = BYTE_W'(mask_reg);
    if (arIdx == IDX_CNT_LO) rdByte = counter_reg[BYTE_W-1:0]; // see [R6]
    if (arIdx == IDX_CNT_HI) rdByte = counter_reg[CNT_W-1:BYTE_W]; // see [R6]
    for (int c = 0; c < NCH; c++) begin
      if (arIdx == IDX_VAL_LO[c]) rdByte = val_reg[c][BYTE_W-1:0]; // see [R7]
      if (arIdx == IDX_VAL_HI[c]) rdByte = val_reg[c][CNT_W-1:BYTE_W]; // see [R7]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arRdy_reg <= 1'b1;
      rValid_reg <= 1'b0;
      rResp_reg <= RESP_OKAY;
      rData_reg <= '0;
    end else if (clkEn) begin
      if (s_axi_arvalid && arRdy_reg) begin
        arRdy_reg <= 1'b0;
        rValid_reg <= 1'b1;
        rData_reg <= 32'(rdByte);
        rResp_reg <= isMapped(arIdx) ? RESP_OKAY : RESP_SLVERR;
      end else if (rValid_reg && s_axi_rready) begin
        rValid_reg <= 1'b0;
        arRdy_reg <= 1'b1;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= MODE_RST;
      rate_reg <= RATE_RST;
      src_reg <= SRC_OFF;
      mask_reg <= FLAG_RST;
    end else if (clkEn) begin
      if (wrMode) mode_reg <= wr.data; // see [R2]
      if (wrRate) rate_reg <= wr.data[RATE_W-1:0]; // see [R1]
      if (wrSrc) src_reg <= tcc_src_t'(wr.data[1:0]); // see [R8]
      if (wrMask) mask_reg <= wr.data[NCH-1:0];
    end
  end

  // Counter: a byte write wins over a count in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_reg <= CNT_RST;
    end else if (clkEn) begin
      if (cntWr) begin
        if (wrCntLo) counter_reg[BYTE_W-1:0] <= wr.data; // see [R6]
        if (wrCntHi) counter_reg[CNT_W-1:BYTE_W] <= wr.data; // see [R6]
      end else if (tick) begin
        counter_reg <= counter_reg + CNT_W'(1); // see [R8]
      end
    end
  end

  // Channel values and compare outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      val_reg <= '0;
      cmpOut_reg <= '0;
    end else if (clkEn) begin
      for (int c = 0; c < NCH; c++) begin
        if (capNow[c]) begin
          val_reg[c] <= counter_reg; // see [R3] see [R9]
        end else begin
          if (wrLo[c]) val_reg[c][BYTE_W-1:0] <= wr.data; // see [R7]
          if (wrHi[c]) val_reg[c][CNT_W-1:BYTE_W] <= wr.data; // see [R7]
        end
        cmpOut_reg[c] <= isCmp[c] && counter_reg >= val_reg[c]; // see [R10]
      end
    end
  end

  // Sticky flags: a new match wins over a write-one clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= FLAG_RST;
      irq_reg <= 1'b0;
    end else if (clkEn) begin
      flag_reg <= (flag_reg & ~flagClr) | match; // see [R11]
      irq_reg <= |(flag_reg & mask_reg);
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_div1_counts;
    (src_reg == SRC_OSC && rate_reg == RATE_DIV1 && clkEn && !cntWr) |=>
      counter_reg == $past(counter_reg) + CNT_W'(1);
  endproperty
  a_div1_counts: assert property (p_div1_counts) else $error("counter did not advance at divide by one"); // see [R1]

  property p_mode_write;
    (wrMode && clkEn) |=> mode_reg == $past(wr.data);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode register not updated by write"); // see [R2]

  property p_pin_capture;
    (chMode[0] == MODE_CAP_PIN && capRise[0] && clkEn) |=> val_reg[0] == $past(counter_reg);
  endproperty
  a_pin_capture: assert property (p_pin_capture) else $error("pin edge did not capture counter"); // see [R3]

  property p_cmp_output;
    (isCmp[1] && clkEn) |=> compareOut[1] == ($past(counter_reg) >= $past(val_reg[1]));
  endproperty
  a_cmp_output: assert property (p_cmp_output) else $error("compare output disagrees with counter"); // see [R10]

  property p_no_cmp_low;
    (!isCmp[2] && clkEn) |=> !compareOut[2];
  endproperty
  a_no_cmp_low: assert property (p_no_cmp_low) else $error("compare output high outside compare mode"); // see [R4]

  property p_sw_capture;
    (wrLo[0] && chMode[0] == MODE_CAP_SW && clkEn) |=> val_reg[0] == $past(counter_reg);
  endproperty
  a_sw_capture: assert property (p_sw_capture) else $error("software capture stored wrong value"); // see [R5]

  property p_cnt_lo_write;
    (wrCntLo && clkEn) |=> counter_reg[BYTE_W-1:0] == $past(wr.data);
  endproperty
  a_cnt_lo_write: assert property (p_cnt_lo_write) else $error("counter low byte not written"); // see [R6]

  property p_val_hi_write;
    (wrHi[0] && !capNow[0] && clkEn) |=> val_reg[0][CNT_W-1:BYTE_W] == $past(wr.data);
  endproperty
  a_val_hi_write: assert property (p_val_hi_write) else $error("channel 0 high byte not written"); // see [R7]

  property p_src_off_holds;
    (src_reg == SRC_OFF && !cntWr) |=> $stable(counter_reg);
  endproperty
  a_src_off_holds: assert property (p_src_off_holds) else $error("counter moved while source is off"); // see [R8]

  property p_sw_replaces_byte;
    (wrLo[3] && chMode[3] == MODE_CAP_SW && clkEn && wr.data != counter_reg[BYTE_W-1:0]) |=>
      val_reg[3][BYTE_W-1:0] != $past(wr.data);
  endproperty
  a_sw_replaces_byte: assert property (p_sw_replaces_byte) else $error("written byte kept on capture"); // see [R9]

  property p_match_flag;
    (match[1] && clkEn) |=> flag_reg[1] ##1 (irq || !$past(mask_reg[1]) || !$past(clkEn));
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match did not set flag or raise interrupt"); // see [R11]

  property p_edge_capture;
    (chMode[2] == MODE_CAP_PIN && clkEn && !wrLo[2] && !wrHi[2] && !capRise[2]) |=> $stable(val_reg[2]);
  endproperty
  a_edge_capture: assert property (p_edge_capture) else $error("value changed without edge"); // see [R12]

  c_pin_capture: cover property (chMode[0] == MODE_CAP_PIN && capRise[0] && clkEn);
  c_sw_capture: cover property (wrLo[1] && chMode[1] == MODE_CAP_SW && clkEn);
  c_match_irq: cover property (match[1] && mask_reg[1] ##2 irq);
  c_flag_clear: cover property (wrFlag && flag_reg != '0);
endmodule

// *** bench/tcc_pin_model.sv ***
// Far-side model driving the four capture pins
`timescale 1ns/100ps
module tcc_pin_model import tcc_pkg::*; (
  // Clock
  input wire logic clk,
  // Bench control
  input wire logic [NCH-1:0] fire,
  output logic busy,
  // Pins
  output logic [NCH-1:0] capturePin
);
  int cnt = 0;
  initial capturePin = '0;
  initial busy = 1'b0;
  // Three high, at least four low: above the two-cycle minimum the synchroniser needs
  always @(posedge clk) begin
    if (cnt == 0 && fire != '0) begin
      capturePin <= fire;
      busy <= 1'b1;
      cnt <= 6;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
      busy <= (cnt > 1);
      if (cnt == 4) begin
        capturePin <= '0;
      end
    end
  end
endmodule

// *** bench/tb_timer2_capture_compare_config.sv ***
// Self-checking bench of the timer capture/compare block
`timescale 1ns/100ps
module tb_timer2_capture_compare_config import tcc_pkg::*; ;
  logic clk = 1'b0;
  logic rstN = 1'b0;
  logic [9:0] awAddr = '0;
  logic [9:0] arAddr = '0;
  logic [31:0] wData = '0;
  logic awValid = 1'b0;
  logic wValid = 1'b0;
  logic bReady = 1'b0;
  logic arValid = 1'b0;
  logic rReady = 1'b0;
  logic [3:0] fire = '0;
  logic clkEn = 1'b1;
  logic [3:0] wStrb = 4'h1;
  logic awReady, wReady, bValid, arReady, rValid, irq, busy;
  logic [1:0] bResp, rResp, lastResp;
  logic [31:0] rData;
  logic [3:0] capPin, cmpOut;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  int tDone = 0;

  tcc_top #(.AW(10)) u_tcc_top (
    .clk(clk), .rst_n(rstN), .clkEn(clkEn),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .capturePin(capPin), .compareOut(cmpOut), .irq(irq)
  );
  tcc_pin_model u_tcc_pin_model (.clk(clk), .fire(fire), .busy(busy), .capturePin(capPin));

  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic final_report();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Run is about 4600 cycles; the ceiling leaves ample slack
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      $display("mismatch at %0t: timeout", $time);
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkRange(input logic [15:0] got, input int lo, input int hi);
    comparisons++;
    if ($isunknown(got) || got < lo || got > hi) begin
      error_cnt++;
      $display("mismatch at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] resp);
    awAddr <= {idx, 2'b00};
    wData <= {24'h00_0000, d};
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge clk);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
    end while (!bValid);
    resp = bResp;
    bReady <= 1'b0;
    tDone = cyc;
    // Let an edge pass so the next call never re-raises bready in this step
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] d);
    arAddr <= {idx, 2'b00};
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge clk);
      if (arReady) arValid <= 1'b0;
    end while (!rValid);
    d = rData;
    lastResp = rResp;
    rReady <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wrOk(input logic [7:0] idx, input logic [7:0] d);
    logic [1:0] resp;
    wr(idx, d, resp);
    chk(resp, RESP_OKAY);
  endtask

  task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    rd(idx, d);
    chk(d, {24'h00_0000, exp});
    chk(lastResp, RESP_OKAY);
  endtask

  task automatic rd16(input logic [7:0] lo, input logic [7:0] hi, output logic [15:0] v);
    logic [31:0] d;
    rd(lo, d);
    v[7:0] = d[7:0];
    rd(hi, d);
    v[15:8] = d[7:0];
  endtask

  task automatic setCnt(input logic [15:0] v);
    wrOk(IDX_CNT_LO, v[7:0]);
    wrOk(IDX_CNT_HI, v[15:8]);
  endtask

  task automatic pulse(input logic [3:0] m);
    fire <= m;
    @(posedge clk);
    fire <= '0;
    @(posedge clk);
    while (busy) begin
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask

  task automatic test_reset();
    logic [7:0] regs [6] = '{IDX_MODE, IDX_RATE, IDX_CNT_LO, IDX_CNT_HI, IDX_VAL_LO[0], IDX_VAL_HI[0]};
    foreach (regs[i]) begin
      rdChk(regs[i], 8'h00);
    end
  endtask

  task automatic test_regs();
    logic [1:0] resp;
    logic [31:0] d;
    wrOk(IDX_MODE, 8'hE4);
    rdChk(IDX_MODE, 8'hE4);
    wrOk(IDX_MODE, 8'h00);
    wrOk(IDX_RATE, 8'hFD);
    rdChk(IDX_RATE, 8'h05);
    wrOk(IDX_VAL_LO[0], 8'h5A);
    wrOk(IDX_VAL_HI[0], 8'hC3);
    rdChk(IDX_VAL_LO[0], 8'h5A);
    rdChk(IDX_VAL_HI[0], 8'hC3);
    setCnt(16'h9B71);
    rdChk(IDX_CNT_LO, 8'h71);
    rdChk(IDX_CNT_HI, 8'h9B);
    // Unmapped index must be refused and leave nothing behind
    wr(8'h00, 8'hFF, resp);
    chk(resp, RESP_SLVERR);
    rd(8'h00, d);
    chk(lastResp, RESP_SLVERR);
    // Lane 0 strobe low: answered but nothing written
    wStrb <= 4'h0;
    wr(IDX_MASK, 8'h0F, resp);
    wStrb <= 4'h1;
    chk(resp, RESP_OKAY);
    rdChk(IDX_MASK, 8'h00);
  endtask

  task automatic test_rate();
    int div;
    int t0;
    logic [15:0] v;
    for (int i = 0; i < 10; i++) begin
      div = (i < 8) ? (128 >> i) : ((i == 8) ? 12 : 24);
      setCnt(16'h0000);
      wrOk(IDX_RATE, (i < 8) ? 8'(i) : 8'h00);
      wrOk(IDX_SRC, (i < 8) ? 8'h03 : 8'(i - 7));
      t0 = tDone;
      repeat (384) @(posedge clk);
      wrOk(IDX_SRC, 8'h00);
      rd16(IDX_CNT_LO, IDX_CNT_HI, v);
      chkRange(v, (tDone - t0) / div - 1, (tDone - t0) / div + 1);
    end
  endtask

  task automatic test_freeze();
    int t0;
    logic [15:0] v;
    setCnt(16'h0000);
    wrOk(IDX_RATE, 8'h07);
    wrOk(IDX_SRC, 8'h03);
    t0 = tDone;
    repeat (20) @(posedge clk);
    // Enable low for 50 edges: those edges must not count
    clkEn <= 1'b0;
    repeat (50) @(posedge clk);
    clkEn <= 1'b1;
    repeat (20) @(posedge clk);
    wrOk(IDX_SRC, 8'h00);
    rd16(IDX_CNT_LO, IDX_CNT_HI, v);
    chkRange(v, tDone - t0 - 51, tDone - t0 - 49);
  endtask

  task automatic test_pin();
    logic [15:0] v;
    wrOk(IDX_MODE, 8'h55);
    for (int n = 0; n < NCH; n++) begin
      setCnt({8'hA5, 8'(n)});
      pulse(4'(1 << n));
      rd16(IDX_VAL_LO[n], IDX_VAL_HI[n], v);
      chk(v, {8'hA5, 8'(n)});
    end
    // Pins must not disturb disabled or comparing channels
    for (int m = 0; m < 2; m++) begin
      wrOk(IDX_MODE, (m == 0) ? 8'h00 : 8'hAA);
      setCnt(16'h1234);
      pulse(4'hF);
      rd16(IDX_VAL_LO[2], IDX_VAL_HI[2], v);
      chk(v, 16'hA502);
    end
  endtask

  task automatic test_sw();
    logic [15:0] v;
    wrOk(IDX_MODE, 8'hFF);
    for (int n = 0; n < NCH; n++) begin
      setCnt({8'h3C, 8'(n * 3)});
      wrOk(IDX_VAL_LO[n], 8'hEE);
      rd16(IDX_VAL_LO[n], IDX_VAL_HI[n], v);
      chk(v, {8'h3C, 8'(n * 3)});
    end
    wrOk(IDX_MODE, 8'h00);
    wrOk(IDX_VAL_LO[0], 8'hEE);
    rdChk(IDX_VAL_LO[0], 8'hEE);
  endtask

  task automatic test_cmp();
    wrOk(IDX_FLAG, 8'h0F);
    wrOk(IDX_MASK, 8'h00);
    setCnt(16'h0020);
    for (int n = 0; n < NCH; n++) begin
      wrOk(IDX_VAL_LO[n], 8'(16 * (n + 1)));
      wrOk(IDX_VAL_HI[n], 8'h00);
    end
    wrOk(IDX_MODE, 8'hAA);
    repeat (3) @(posedge clk);
    chk(cmpOut, 4'b0011);
    rdChk(IDX_FLAG, 8'h02);
    chk(irq, 1'b0);
    wrOk(IDX_MASK, 8'h02);
    repeat (3) @(posedge clk);
    chk(irq, 1'b1);
    wrOk(IDX_MODE, 8'h00);
    wrOk(IDX_FLAG, 8'h02);
    repeat (3) @(posedge clk);
    chk(cmpOut, 4'b0000);
    rdChk(IDX_FLAG, 8'h00);
    chk(irq, 1'b0);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rstN <= 1'b1;
    @(posedge clk);
    test_reset();
    test_regs();
    test_rate();
    test_freeze();
    test_pin();
    test_sw();
    test_cmp();
    final_report();
  end
endmodule
